// File: inc/srw_pkg.sv
// Shared constants and carrier types for the supervisor reset watchdog.
// Assumes a 10 MHz system clock; all times become cycle counts here.
package srw_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // Reset hold period in milliseconds and its cycle count.
  localparam int unsigned HOLD_MS     = 200;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);

  // Watchdog timeout in milliseconds (1.6 s nominal) and cycle count.
  localparam int unsigned WDOG_MS     = 1600;
  localparam int unsigned WDOG_CYCLES = WDOG_MS * (CLK_HZ / 1000);

  // Internal service driver is low for 7/8 and high for 1/8 of a period.
  localparam int unsigned SVC_NUM     = 7;
  localparam int unsigned SVC_DEN     = 8;

  // Manual reset shorter than 100 ns is noise; 1.0 us is always taken.
  localparam int unsigned MR_FILT_NS     = 500;
  localparam int unsigned MR_FILT_CYCLES = (MR_FILT_NS * (CLK_HZ / 1_000_000)
                                            + 999) / 1000;

  // Supply glitch rejection of 15 us, rounded down to cycles.
  localparam int unsigned GLITCH_US     = 15;
  localparam int unsigned GLITCH_CYCLES = GLITCH_US * (CLK_HZ / 1_000_000);

  // Reset state after power up.
  localparam logic RESET_ASSERTED_AT_RESET = 1'b1;

  // Reset causes gathered together.
  typedef struct packed {
    logic supply_low;
    logic manual;
    logic watchdog;
  } srw_cause_t;

  // Hold sequencer states.
  typedef enum logic [0:0] {
    SRW_HOLD = 1'b0,
    SRW_RUN  = 1'b1
  } srw_state_t;

endpackage

// File: rtl/srw_filter.sv
// Level filter: output follows the input only after it stays stable
// for a set number of cycles. Inputs are synchronous to the clock.
`timescale 1ns/100ps

module srw_filter #(
  parameter int unsigned CYCLES = 5,
  parameter logic        INIT   = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic          dout_reg;

  // Count while the input differs from the output; any agreement restarts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      dout_reg <= INIT;
    end else if (din == dout_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= CW'(CYCLES - 1)) begin
      cnt_reg  <= '0;
      dout_reg <= din;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign dout = dout_reg;

endmodule // srw_filter

// File: rtl/srw_top.sv
// Supervisor reset watchdog: reset sequencer, watchdog timer and the
// internal service driver for a floating kick input.
// Assumes all inputs synchronous to CLOCK, and the kick pin's wire level
// resolved outside from KICK_OE and KICK_OUT.
// Timing in short, in clock cycles of CLOCK:
// A supply or manual cause must pass its level filter before it counts.
// The supply filter needs GLITCH_CYCLES steady samples and the manual
// filter needs MR_FILT_CYCLES. Once a filtered cause is present, the hold
// sequencer is forced back to its hold state with a cleared count. The
// active-low reset output falls on that same edge. When every cause
// has gone, the hold count runs for HOLD_CYCLES. The sequencer moves to
// run and the reset outputs release one edge later.
//
// The watchdog fires when no kick edge has been seen for WDOG_CYCLES
// cycles while reset is released. The fire flag lasts one cycle and is
// treated like any other cause, so a watchdog reset lasts a full hold
// period as well.
//
// The internal service driver runs one cycle faster than the timeout.
// A floating pin therefore always sees an edge before the timer fires.
// The trade-off is that the service high phase is one cycle shorter
// than an exact eighth of the timeout.
`timescale 1ns/100ps

module srw_top #(
  parameter int unsigned HOLD_CYCLES   = srw_pkg::HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES   = srw_pkg::WDOG_CYCLES,
  parameter int unsigned GLITCH_CYCLES = srw_pkg::GLITCH_CYCLES
) (
  input  wire logic CLOCK,
  input  wire logic RST_B,
  input  wire logic SUPPLY_LOW,
  input  wire logic MANUAL_RESET_IN_N,
  input  wire logic WATCHDOG_KICK_IN,
  output logic      WATCHDOG_KICK_OUT,
  output logic      WATCHDOG_KICK_OE,
  output logic      RESET_OUT_N,
  output logic      RESET_OUT
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned WW = $clog2(WDOG_CYCLES + 1);
  localparam int unsigned SVC_HIGH_AT =
    (WDOG_CYCLES * srw_pkg::SVC_NUM) / srw_pkg::SVC_DEN;
  // The service driver runs a little fast so it always beats the timer.
  localparam int unsigned SVC_PERIOD = SVC_HIGH_AT + WDOG_CYCLES / 8 - 1;

  srw_pkg::srw_cause_t cause;
  srw_pkg::srw_state_t state_reg;
  logic [HW-1:0]       hold_cnt_reg;
  logic [WW-1:0]       wdog_cnt_reg;
  logic [WW-1:0]       svc_cnt_reg;
  logic                kick_prev_reg;
  logic                wdog_fire_reg;
  logic                supply_low_f;
  logic                manual_n_f;
  logic                reset_n_reg;
  logic                reset_reg;
  logic                svc_out_reg;
  logic                kick_oe_reg;
  logic                kick_edge;

  // Supply comparator output is filtered so short dips are ignored.
  srw_filter #(
    .CYCLES (GLITCH_CYCLES),
    .INIT   (1'b1)
  ) u_supply_filter (
    .clk   (CLOCK),
    .rst_n (RST_B),
    .din   (SUPPLY_LOW),
    .dout  (supply_low_f)
  );

  // Manual input is filtered; bounces shorter than the window collapse.
  srw_filter #(
    .CYCLES (srw_pkg::MR_FILT_CYCLES),
    .INIT   (1'b1)
  ) u_manual_filter (
    .clk   (CLOCK),
    .rst_n (RST_B),
    .din   (MANUAL_RESET_IN_N),
    .dout  (manual_n_f)
  );

  // Every cause that forces reset while it is present.
  always_comb begin
    cause.supply_low = supply_low_f;
    cause.manual     = !manual_n_f;
    cause.watchdog   = wdog_fire_reg;
  end

  // Hold sequencer: any cause reloads the hold count, so each new dip or
  // press restarts the full hold period after it clears.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg    <= srw_pkg::SRW_HOLD;
      hold_cnt_reg <= '0;
    end else if (|cause) begin
      state_reg    <= srw_pkg::SRW_HOLD;
      hold_cnt_reg <= '0;
    end else begin
      case (state_reg)
        srw_pkg::SRW_HOLD: begin
          if (hold_cnt_reg >= HW'(HOLD_CYCLES - 1)) begin
            state_reg <= srw_pkg::SRW_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + HW'(1);
          end
        end
        srw_pkg::SRW_RUN: begin
          hold_cnt_reg <= '0;
        end
        default: begin
          state_reg <= srw_pkg::SRW_HOLD;
        end
      endcase
    end
  end

  // Reset outputs come from flip-flops and are always complementary.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      reset_n_reg <= !srw_pkg::RESET_ASSERTED_AT_RESET;
      reset_reg   <= srw_pkg::RESET_ASSERTED_AT_RESET;
    end else begin
      reset_n_reg <= (state_reg == srw_pkg::SRW_RUN) && !(|cause);
      reset_reg   <= !((state_reg == srw_pkg::SRW_RUN) && !(|cause));
    end
  end

  // Kick pin is sampled every cycle; at 100 ns a 50 ns pulse can slip
  // between edges, so the pin's pulses must span one clock edge.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= WATCHDOG_KICK_IN;
    end
  end

  assign kick_edge = WATCHDOG_KICK_IN ^ kick_prev_reg;

  // Watchdog timer: held clear during reset, cleared by any kick edge,
  // fires once it reaches the timeout and holds the cause for one cycle.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wdog_cnt_reg  <= '0;
      wdog_fire_reg <= 1'b0;
    end else if (!reset_n_reg || kick_edge) begin
      wdog_cnt_reg  <= '0;
      wdog_fire_reg <= 1'b0;
    end else if (wdog_cnt_reg >= WW'(WDOG_CYCLES - 1)) begin
      wdog_cnt_reg  <= '0;
      wdog_fire_reg <= 1'b1;
    end else begin
      wdog_cnt_reg  <= wdog_cnt_reg + WW'(1);
      wdog_fire_reg <= 1'b0;
    end
  end

  // Internal service driver: low for the first 7/8 of its period, high
  // for the rest. It is free running so a floating pin never times out.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      svc_cnt_reg <= '0;
      svc_out_reg <= 1'b0;
    end else begin
      if (svc_cnt_reg >= WW'(SVC_PERIOD - 1)) begin
        svc_cnt_reg <= '0;
      end else begin
        svc_cnt_reg <= svc_cnt_reg + WW'(1);
      end
      svc_out_reg <= (svc_cnt_reg >= WW'(SVC_HIGH_AT - 1)) &&
                     (svc_cnt_reg <  WW'(SVC_PERIOD - 1));
    end
  end

  // Weak service drive is enabled from the first edge after reset.
  // It comes from a flip-flop so the pin enable never glitches with reset.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      kick_oe_reg <= 1'b0;
    end else begin
      kick_oe_reg <= 1'b1;
    end
  end

  // All outputs come straight from flip-flops.
  assign WATCHDOG_KICK_OUT = svc_out_reg;
  assign WATCHDOG_KICK_OE  = kick_oe_reg;
  assign RESET_OUT_N       = reset_n_reg;
  assign RESET_OUT         = reset_reg;

endmodule // srw_top

// File: sim/srw_checker.sv
// Port checker for the supervisor reset watchdog.
// Assumes bind onto srw_top with the same cycle-count parameters.
`timescale 1ns/100ps
module srw_checker #(
  parameter int unsigned HOLD_CYCLES = 50,
  parameter int unsigned WDOG_CYCLES = 400
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic SUPPLY_LOW,
  input wire logic MANUAL_RESET_IN_N,
  input wire logic WATCHDOG_KICK_IN,
  input wire logic WATCHDOG_KICK_OUT,
  input wire logic WATCHDOG_KICK_OE,
  input wire logic RESET_OUT_N,
  input wire logic RESET_OUT
);
  int unsigned low_cnt;
  int unsigned idle_cnt;
  logic        kick_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Run lengths of reset low and of a kick pin with no edge.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      low_cnt  <= 0;
      idle_cnt <= 0;
      kick_q   <= 1'h0;
    end else begin
      low_cnt  <= RESET_OUT_N ? 0 : low_cnt + 1;
      idle_cnt <= (!RESET_OUT_N || kick_q != WATCHDOG_KICK_IN) ? 0
                  : idle_cnt + 1;
      kick_q   <= WATCHDOG_KICK_IN;
    end
  end
  AST_INV: assert property (RESET_OUT == !RESET_OUT_N)
    else $error("active-high reset is not the inverse");
  AST_SUP: assert property (SUPPLY_LOW [*8] |-> !RESET_OUT_N)
    else $error("low supply did not hold reset");
  AST_MAN: assert property (!MANUAL_RESET_IN_N [*8] |=> !RESET_OUT_N)
    else $error("manual reset not taken");
  AST_HOLD: assert property ($rose(RESET_OUT_N) |-> low_cnt >= HOLD_CYCLES)
    else $error("reset released before the hold period");
  AST_GLITCH: assert property (RESET_OUT_N && !SUPPLY_LOW ##1 SUPPLY_LOW [*2]
    ##1 !SUPPLY_LOW |-> RESET_OUT_N)
    else $error("short supply glitch gave a reset");
  AST_WDOG: assert property (idle_cnt <= WDOG_CYCLES + 4)
    else $error("watchdog did not expire in time");
  AST_OE: assert property (RESET_OUT_N |-> WATCHDOG_KICK_OE)
    else $error("service drive not enabled");
  AST_SVC: assert property ($fell(WATCHDOG_KICK_OUT) |->
    ##[300:400] $rose(WATCHDOG_KICK_OUT))
    else $error("service pulse period wrong");
endmodule // srw_checker
bind srw_top srw_checker #(.HOLD_CYCLES(HOLD_CYCLES),
  .WDOG_CYCLES(WDOG_CYCLES)) u_srw_checker (.*);

// File: sim/srw_kick_partner.sv
// Processor side of the kick pin, resolving the pin's wire level.
// Assumes the bench sets drv_en and drv_val just after clock edges.
`timescale 1ns/100ps
module srw_kick_partner (
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic kick_oe,
  input  wire logic kick_out,
  output logic      kick_wire
);
  // A strong external driver wins over the weak internal one.
  always_comb begin
    kick_wire = drv_en ? drv_val : (kick_oe ? kick_out : 1'h0);
  end
endmodule // srw_kick_partner

// File: sim/srw_top_tb.sv
// Self-checking bench for the supervisor reset watchdog.
// Assumes short counts: hold 50, timeout 400 and glitch 3 cycles.
`timescale 1ns/100ps
module srw_top_tb;
  localparam int HOLD = 50;
  localparam int WDOG = 400;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic sup = 1'h0;
  logic man_n = 1'h1;
  logic drv_en = 1'h0;
  logic drv_val = 1'h0;
  logic kick, k_out, k_oe, r_n, r_p;
  int   mismatches = 0;
  int   n_checks = 0;
  int   cycles = 0;
  int   n;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  srw_top #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .GLITCH_CYCLES(3)) u_srw_top (
    .CLOCK(clk), .RST_B(rst_b), .SUPPLY_LOW(sup), .MANUAL_RESET_IN_N(man_n),
    .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_OUT(k_out),
    .WATCHDOG_KICK_OE(k_oe), .RESET_OUT_N(r_n), .RESET_OUT(r_p));
  srw_kick_partner u_srw_kick_partner (.drv_en(drv_en), .drv_val(drv_val),
    .kick_oe(k_oe), .kick_out(k_out), .kick_wire(kick));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Counts cycles, up to lim, until reset output reaches v.
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    @(negedge clk);
    while (r_n !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic t_supply();
    sup <= 1'h1;
    repeat (2) @(posedge clk);
    sup <= 1'h0;
    wait_rst(1'h0, 10); check(32'(n), 32'h0000_000a);
    sup <= 1'h1;
    wait_rst(1'h0, 8); check(32'(r_p), 32'h0000_0001);
    repeat (20) @(posedge clk);
    sup <= 1'h0;
    repeat (20) @(posedge clk);
    sup <= 1'h1;
    repeat (10) @(posedge clk);
    sup <= 1'h0;
    wait_rst(1'h1, HOLD + 20); check(32'(n >= HOLD && r_n), 32'h0000_0001);
  endtask
  task automatic t_manual();
    man_n <= 1'h0;
    repeat (3) @(posedge clk);
    man_n <= 1'h1;
    wait_rst(1'h0, 10); check(32'(n), 32'h0000_000a);
    for (int i = 0; i < 6; i++) begin
      man_n <= i[0];
      repeat (2) @(posedge clk);
    end
    man_n <= 1'h0;
    repeat (20) @(posedge clk);
    man_n <= 1'h1;
    wait_rst(1'h1, HOLD + 20); check(32'(n >= HOLD && r_n), 32'h0000_0001);
    wait_rst(1'h0, 100); check(32'(n), 32'h0000_0064);
  endtask
  task automatic t_wdog();
    drv_en <= 1'h1;
    drv_val <= 1'h1;
    @(posedge clk);
    drv_val <= 1'h0;
    wait_rst(1'h0, WDOG + 20); check(32'(n >= WDOG - 2 && n <= WDOG + 4), 32'h0000_0001);
    wait_rst(1'h1, HOLD + 20); check(32'(r_n), 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      wait_rst(1'h0, 300); check(32'(n), 32'h0000_012c);
      drv_val <= 1'h1;
      @(posedge clk);
      drv_val <= 1'h0;
    end
    drv_en <= 1'h0;
    wait_rst(1'h0, 1500); check(32'(n), 32'h0000_05dc);
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    wait_rst(1'h1, HOLD + 20); check(32'(n >= HOLD && r_n), 32'h0000_0001);
    t_supply();
    t_manual();
    t_wdog();
    end_sim();
  end
endmodule // srw_top_tb
